// *** hdl/ppvc_pkg.sv ***
// constants shared by the port power and vconn control block
`default_nettype none
package ppvc_pkg;
  // clock period
  localparam int unsigned CLK_PERIOD_NS = 10;
  // synchroniser lanes: mic detect, port 4 pin, four cc comparators
  localparam int SYNC_W = 6;
  localparam int B_MIC = 0;
  localparam int B_OCS = 1;
  localparam int B_CC = 2;
  // vconn lanes in order p1cc1, p1cc2, p2cc1, p2cc2; discharge lanes p1, p2
  localparam int NUM_VCONN = 4;
  localparam int NUM_DISCH = 2;
  // sticky status layout: vconn faults in [3:0], port 4 overcurrent in [4]
  localparam int NUM_FAULT = 5;
  localparam int F_OC = 4;
  // longest discharge pulse, rounded down to whole cycles
  localparam int unsigned DISCH_MAX_US = 100;
  localparam int unsigned DISCH_MAX_CYC = DISCH_MAX_US * 1000 / CLK_PERIOD_NS;
  // overcurrent blanking after port 4 power-up, rounded up
  localparam int unsigned OC_BLANK_NS = 2000;
  localparam int unsigned OC_BLANK_CYC = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_BLANK_W = $clog2(OC_BLANK_CYC + 1);
  // values after reset
  localparam logic [NUM_VCONN-1:0] VCONN_RST = 4'h0;
  localparam logic [NUM_FAULT-1:0] FAULT_RST = 5'h00;
endpackage : ppvc_pkg
`default_nettype wire

// *** hdl/ppvc_sync.sv ***
// two-flop synchroniser for the asynchronous sense inputs
`default_nettype none
module ppvc_sync
  import ppvc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  ppvc_sync_if.sync sif
);
  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } ppvc_sync_st_t;

  ppvc_sync_st_t st_q;
  ppvc_sync_st_t st_d;

  // meta feeds only stable, nothing else looks at it
  always_comb
  begin
    st_d.meta = sif.raw;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sif.synced = st_q.stable;
endmodule // ppvc_sync
`default_nettype wire

// *** hdl/ppvc_sync_if.sv ***
// raw pin levels in, clock-aligned levels out
`default_nettype none
interface ppvc_sync_if;
  logic [ppvc_pkg::SYNC_W-1:0] raw;
  logic [ppvc_pkg::SYNC_W-1:0] synced;
  modport feed (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : ppvc_sync_if
`default_nettype wire

// *** hdl/ppvc_top.sv ***
// port power, vbus discharge and vconn control with fault status
`default_nettype none
module ppvc_top
  import ppvc_pkg::*;
#(
  parameter int unsigned DISCH_MAX = ppvc_pkg::DISCH_MAX_CYC
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mic_plug_detect,
  input wire logic [ppvc_pkg::NUM_VCONN-1:0] cc_above_3v0,
  input wire logic [ppvc_pkg::NUM_VCONN-1:0] vconn_request,
  input wire logic [ppvc_pkg::NUM_DISCH-1:0] discharge_request,
  input wire logic port4_cfg_enable,
  input wire logic port4_host_enable,
  input wire logic port4_power_ocs_pin_i,
  input wire logic [ppvc_pkg::NUM_FAULT-1:0] fault_clear,
  output logic port1_cc1_vconn_enable,
  output logic port1_cc2_vconn_enable,
  output logic port2_cc1_vconn_enable,
  output logic port2_cc2_vconn_enable,
  output logic port1_vbus_discharge_enable,
  output logic port2_vbus_discharge_enable,
  output logic port4_power_ocs_pin_o,
  output logic port4_power_ocs_pin_oe_b,
  output logic port4_pullup_enable,
  output logic port4_usb2_power,
  output logic port4_usb3_power,
  output logic port4_overcurrent,
  output logic mic_present,
  output logic [ppvc_pkg::NUM_VCONN-1:0] vconn_fault,
  output logic [ppvc_pkg::NUM_FAULT-1:0] fault_status
);
  import ppvc_pkg::*;

  localparam int DCW = $clog2(DISCH_MAX + 1);
  localparam logic [DCW-1:0] DISCH_LIMIT = DCW'(DISCH_MAX);
  localparam logic [OC_BLANK_W-1:0] OC_BLANK_LOAD = OC_BLANK_W'(OC_BLANK_CYC);

  typedef struct packed {
    logic [NUM_VCONN-1:0] vconn;
    logic [NUM_VCONN-1:0] vfault;
    logic [NUM_DISCH-1:0] disch;
    logic [NUM_DISCH-1:0][DCW-1:0] dcnt;
    logic p4_on;
    logic [OC_BLANK_W-1:0] blank;
    logic oc;
    logic mic;
    logic [NUM_FAULT-1:0] sticky;
  } ppvc_st_t;

  ppvc_st_t st_q;
  ppvc_st_t st_d;

  // port 4 is powered only when configuration and host both allow it
  function automatic logic p4_enabled(input logic cfg, input logic host);
    return cfg & host;
  endfunction

  // pin levels from outside the clock domain pass two flops first
  ppvc_sync_if sif ();

  assign sif.raw = {cc_above_3v0, port4_power_ocs_pin_i, mic_plug_detect};

  ppvc_sync u_sync (
    .mclk (mclk),
    .rst_b (rst_b),
    .sif (sif)
  );

  // next state of the whole block
  always_comb
  begin
    st_d = st_q;
    st_d.mic = sif.synced[B_MIC];
    st_d.vconn = vconn_request;
    // fault compares what is driven now against the settled comparator
    st_d.vfault = st_q.vconn & ~sif.synced[B_CC +: NUM_VCONN];
    for (int i = 0; i < NUM_DISCH; i++)
    begin
      // counter parks at the limit so a stuck request cannot re-arm it
      if (!discharge_request[i])
      begin
        st_d.disch[i] = 1'b0;
        st_d.dcnt[i] = '0;
      end
      else if (st_q.dcnt[i] == DISCH_LIMIT)
      begin
        st_d.disch[i] = 1'b0;
      end
      else
      begin
        st_d.disch[i] = 1'b1;
        st_d.dcnt[i] = st_q.dcnt[i] + 1'b1;
      end
    end
    st_d.p4_on = p4_enabled(port4_cfg_enable, port4_host_enable);
    // pull-up needs time to lift the pin that was just driven low
    if (!st_q.p4_on)
      st_d.blank = OC_BLANK_LOAD;
    else if (st_q.blank != '0)
      st_d.blank = st_q.blank - 1'b1;
    st_d.oc = st_q.p4_on & (st_q.blank == '0) & ~sif.synced[B_OCS];
    // a new fault wins over a clear in the same cycle
    st_d.sticky = (st_q.sticky & ~fault_clear) | {st_d.oc, st_d.vfault};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.vconn <= VCONN_RST;
      st_q.sticky <= FAULT_RST;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from the state flops, except the port 4 pin drive level, tied low
  assign port1_cc1_vconn_enable = st_q.vconn[0];
  assign port1_cc2_vconn_enable = st_q.vconn[1];
  assign port2_cc1_vconn_enable = st_q.vconn[2];
  assign port2_cc2_vconn_enable = st_q.vconn[3];
  assign port1_vbus_discharge_enable = st_q.disch[0];
  assign port2_vbus_discharge_enable = st_q.disch[1];
  // enabled: released to the pull-up; disabled: driven low
  assign port4_power_ocs_pin_o = 1'b0;
  assign port4_power_ocs_pin_oe_b = st_q.p4_on;
  assign port4_pullup_enable = st_q.p4_on;
  // both halves of port 4 share the one control
  assign port4_usb2_power = st_q.p4_on;
  assign port4_usb3_power = st_q.p4_on;
  assign port4_overcurrent = st_q.oc;
  assign mic_present = st_q.mic;
  assign vconn_fault = st_q.vfault;
  assign fault_status = st_q.sticky;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  property p_mic_follows;
    ##1 mic_present == $past(sif.synced[B_MIC]);
  endproperty
  a_mic_follows: assert property (p_mic_follows)
    else $error("mic present does not follow detect pin");

  property p_vconn_follows;
    ##1 {port2_cc2_vconn_enable, port2_cc1_vconn_enable,
         port1_cc2_vconn_enable, port1_cc1_vconn_enable} == $past(vconn_request);
  endproperty
  a_vconn_follows: assert property (p_vconn_follows)
    else $error("vconn enables do not follow request");

  property p_vconn_fault;
    ##1 vconn_fault == $past({port2_cc2_vconn_enable, port2_cc1_vconn_enable,
         port1_cc2_vconn_enable, port1_cc1_vconn_enable} & ~sif.synced[B_CC +: NUM_VCONN]);
  endproperty
  a_vconn_fault: assert property (p_vconn_fault)
    else $error("vconn fault mismatch");

  property p_disch_drop;
    !discharge_request[0] |=> !port1_vbus_discharge_enable;
  endproperty
  a_disch_drop: assert property (p_disch_drop)
    else $error("discharge held without request");

  property p_disch_brief;
    port2_vbus_discharge_enable |-> st_q.dcnt[1] != '0 && st_q.dcnt[1] <= DISCH_LIMIT;
  endproperty
  a_disch_brief: assert property (p_disch_brief)
    else $error("discharge pulse too long");

  property p_p4_input;
    p4_enabled(port4_cfg_enable, port4_host_enable)
      |=> port4_power_ocs_pin_oe_b && port4_pullup_enable;
  endproperty
  a_p4_input: assert property (p_p4_input)
    else $error("port 4 pin not released with pull-up");

  property p_p4_oc;
    st_q.p4_on && st_q.blank == '0 && !sif.synced[B_OCS] |=> port4_overcurrent ##0 fault_status[F_OC];
  endproperty
  a_p4_oc: assert property (p_p4_oc)
    else $error("overcurrent missed");

  property p_p4_off;
    !p4_enabled(port4_cfg_enable, port4_host_enable)
      |=> !port4_power_ocs_pin_oe_b && !port4_power_ocs_pin_o ##1 !port4_overcurrent;
  endproperty
  a_p4_off: assert property (p_p4_off)
    else $error("port 4 pin not driven low when disabled");

  property p_p4_both;
    port4_usb2_power == port4_usb3_power && port4_usb3_power == port4_pullup_enable;
  endproperty
  a_p4_both: assert property (p_p4_both)
    else $error("port 4 halves disagree");

  property p_sticky_hold;
    fault_status[0] && !fault_clear[0] |=> fault_status[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("fault status lost without clear");

  c_disch_timeout: cover property (port1_vbus_discharge_enable ##1 !port1_vbus_discharge_enable
    && discharge_request[0]);
  c_overcurrent: cover property ($rose(port4_overcurrent));
  c_vconn_fault: cover property ($rose(vconn_fault[2]));
endmodule // ppvc_top
`default_nettype wire

// *** testbench/port_power_vconn_control_tb.sv ***
// self-checking bench for the port power and vconn control block
`default_nettype none
module port_power_vconn_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppvc_pkg::*;
  localparam int DM = 20;
  logic mclk = 0, rst_b = 0, mic = 0, cfg = 0, host = 0, oc_pull = 0;
  logic [3:0] vreq = '0, cc_ok = '0;
  logic [1:0] dreq = '0;
  logic [4:0] clr = '0;
  logic pin, p_o, p_oe_b, pu, u2, u3, oc, micp, v11, v12, v21, v22, d1, d2;
  logic [3:0] cc, vf;
  logic [4:0] fs;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  ppvc_top #(.DISCH_MAX(DM)) ppvc_top_inst (.mclk(mclk), .rst_b(rst_b),
    .mic_plug_detect(mic), .cc_above_3v0(cc), .vconn_request(vreq),
    .discharge_request(dreq), .port4_cfg_enable(cfg), .port4_host_enable(host),
    .port4_power_ocs_pin_i(pin), .fault_clear(clr), .port1_cc1_vconn_enable(v11),
    .port1_cc2_vconn_enable(v12), .port2_cc1_vconn_enable(v21),
    .port2_cc2_vconn_enable(v22), .port1_vbus_discharge_enable(d1),
    .port2_vbus_discharge_enable(d2), .port4_power_ocs_pin_o(p_o),
    .port4_power_ocs_pin_oe_b(p_oe_b), .port4_pullup_enable(pu), .port4_usb2_power(u2),
    .port4_usb3_power(u3), .port4_overcurrent(oc), .mic_present(micp),
    .vconn_fault(vf), .fault_status(fs));
  ppvc_far_side ppvc_far_side_inst (.mclk(mclk), .pin_o(p_o), .pin_oe_b(p_oe_b),
    .pullup_enable(pu), .oc_pull(oc_pull), .cc_ok(cc_ok), .pin(pin), .cc_above(cc));
  // free-running clock, 10 ns period
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // all four lanes at once, two with a dead cc line
  task automatic t_vconn();
    cc_ok = 4'h5;
    step(3);
    vreq = 4'hf;
    step(1);
    check("vconn_en", {v22, v21, v12, v11}, 8'h0f);
    step(1);
    check("vconn_fault", vf, 8'h0a);
    check("fault_status", fs, 8'h0a);
    vreq = 4'h0;
    step(2);
    check("vconn_off", {v22, v21, v12, v11, vf}, 8'h00);
    check("status_sticky", fs, 8'h0a);
    clr = 5'h0f;
    step(1);
    clr = 5'h00;
    check("status_clr", fs, 8'h00);
    // a clear that meets a live fault must lose
    vreq = 4'h2;
    step(2);
    clr = 5'h0f;
    step(1);
    check("status_set_wins", fs, 8'h02);
    vreq = 4'h0;
    step(2);
    clr = 5'h00;
    check("status_clr2", fs, 8'h00);
  endtask
  // held request must time out after DM cycles
  task automatic t_disch();
    dreq = 2'h3;
    step(1);
    check("disch_on", {d2, d1}, 8'h03);
    step(DM - 1);
    check("disch_last", {d2, d1}, 8'h03);
    step(1);
    check("disch_timeout", {d2, d1}, 8'h00);
    dreq = 2'h0;
    step(2);
    dreq = 2'h2;
    step(3);
    check("disch_rearm", {d2, d1}, 8'h02);
    dreq = 2'h0;
    step(1);
    check("disch_release", {d2, d1}, 8'h00);
  endtask
  // port 4 power, overcurrent after blanking, host disable
  task automatic t_port4();
    cfg = 1;
    host = 1;
    step(1);
    check("p4_on", {p_oe_b, pu, u2, u3}, 8'h0f);
    step(OC_BLANK_CYC + 5);
    check("p4_no_oc", oc, 8'h00);
    oc_pull = 1;
    step(3);
    check("p4_oc", {oc, fs[F_OC]}, 8'h03);
    oc_pull = 0;
    host = 0;
    step(1);
    check("p4_off", {p_oe_b, pin, pu, u2, u3}, 8'h00);
    step(1);
    check("p4_oc_off", {oc, fs[F_OC]}, 8'h01);
    clr = 5'h10;
    step(1);
    clr = 5'h00;
    check("p4_clr", fs, 8'h00);
    // host allows it but configuration does not: pin stays driven low
    cfg = 0;
    host = 1;
    step(2);
    check("p4_cfg_off", {p_oe_b, pin, pu, u2, u3}, 8'h00);
    host = 0;
  endtask
  // microphone detect both ways
  task automatic t_mic();
    mic = 1;
    step(3);
    check("mic_in", micp, 8'h01);
    mic = 0;
    step(3);
    check("mic_out", micp, 8'h00);
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    step(2);
    check("rst_pin", {p_oe_b, p_o, pu, u2, u3, oc, micp}, 8'h00);
    rst_b = 1;
    step(3);
    t_vconn();
    t_disch();
    t_port4();
    t_mic();
    end_of_test();
  end
endmodule // port_power_vconn_control_tb
`default_nettype wire

// *** testbench/ppvc_far_side.sv ***
// model of the port 4 pin wiring, current monitor and cc comparators
`default_nettype none
module ppvc_far_side
(
  input wire logic mclk,
  input wire logic pin_o,
  input wire logic pin_oe_b,
  input wire logic pullup_enable,
  input wire logic oc_pull,
  input wire logic [3:0] cc_ok,
  output logic pin,
  output logic [3:0] cc_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  // no keeper on a floating pin: show the inverse so a stale value is never read as good
  always_comb
  begin
    if (!pin_oe_b)
      pin = pin_o;
    else if (oc_pull)
      pin = 1'b0;
    else if (pullup_enable)
      pin = 1'b1;
    else
      pin = ~last_q;
  end
  // remember the last level for the floating case
  always @(posedge mclk)
    last_q <= pin;
  // comparator high wherever cc_ok marks the line good, whether vconn is driven or not
  assign cc_above = cc_ok;
endmodule // ppvc_far_side
`default_nettype wire
